// File: hw/usx_pkg.sv
// Constants, register map and carrier types for the serial transceiver.
// Assumes a byte-wide register port and a single system clock.
package usx_pkg;
    // Register map
    localparam logic [7:0] ADDR_STATUS = 8'hC0;
    localparam logic [7:0] ADDR_CTRL = 8'hC1;
    localparam logic [7:0] ADDR_FORMAT = 8'hC2;
    localparam logic [7:0] ADDR_BAUD_LO = 8'hC4;
    localparam logic [7:0] ADDR_BAUD_HI = 8'hC5;
    localparam logic [7:0] ADDR_DATA = 8'hC6;

    // Status/control first register bit positions
    localparam int A_RXC = 7;
    localparam int A_TXC = 6;
    localparam int A_UDRE = 5;
    localparam int A_FE = 4;
    localparam int A_DOR = 3;
    localparam int A_PE = 2;
    localparam int A_U2X = 1;
    localparam int A_MPCM = 0;

    // Control second register bit positions
    localparam int B_RXCIE = 7;
    localparam int B_TXCIE = 6;
    localparam int B_UDRIE = 5;
    localparam int B_RXEN = 4;
    localparam int B_TXEN = 3;
    localparam int B_CSZ2 = 2;
    localparam int B_RXB8 = 1;
    localparam int B_TXB8 = 0;

    // Frame format register bit positions
    localparam int C_MSEL = 6;
    localparam int C_PAR_HI = 5;
    localparam int C_PAR_LO = 4;
    localparam int C_STOP = 3;
    localparam int C_CSZ_HI = 2;
    localparam int C_CSZ_LO = 1;
    localparam int C_CPOL = 0;

    // Reset values and masks
    localparam logic [7:0] FORMAT_RESET = 8'h06;
    localparam logic [7:0] FORMAT_MASK = 8'h7F;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // Oversampling counts per bit, minus one
    localparam logic [3:0] OS_NORMAL = 4'hF;
    localparam logic [3:0] OS_DOUBLE = 4'h7;

    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} usx_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usx_rx_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } usx_bus_req_t;

    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic pe;
    } usx_rx_ent_t;

    typedef struct packed {
        logic u2x;
        logic mpcm;
        logic txc;
        logic [7:0] ctrl_b;
        logic [7:0] fmt;
        logic [11:0] baud;
        logic [11:0] presc;
        logic external_serial_clock;
        logic [3:0] tx_os;
        logic [3:0] rx_os;
        usx_tx_state_t tx_st;
        logic [8:0] tx_buf;
        logic tx_full;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_par;
        logic tx_on;
        logic txd;
        logic txd_oe_n;
        logic xck_oe_n;
        usx_rx_state_t rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_cnt;
        logic rx_par;
        logic rx_pe;
        usx_rx_ent_t [1:0] fifo;
        logic [1:0] fifo_n;
        usx_rx_ent_t hold;
        logic hold_v;
        logic dor;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic rxd;
        logic [7:0] rdata;
        logic irq_rx;
        logic irq_tx;
        logic irq_udre;
    } usx_state_t;
endpackage : usx_pkg

// File: hw/usx_regs.sv
// Serial transceiver: control/status/baud registers with a compact frame engine.
// Assumes a byte register port with one-cycle strobes and read data one cycle later.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// (R1) Transmit-done sets after last frame, buffer empty
// (R2) Transmit-done clears on service or write-one
// (R3) Buffer-empty reads one when buffer free, reset
// (R4) Framing fault follows head character's stop bit
// (R5) Overrun when buffer, holder full, new start
// (R6) Parity fault follows head character when checked
// (R7) Software writes zero to fault bit positions
// (R8) Double speed divides by eight, async only
// (R9) Multidrop filter drops frames without address mark
// (R10) Interrupt requests need enable, global, flag
// (R11) Receiver disable flushes buffer and faults
// (R12) Transmitter disable waits until everything sent
// (R13) Software reads ninth bit before data
// (R14) Software writes ninth bit before data
// (R15) Mode bit selects asynchronous or synchronous
// (R16) Parity field: off, reserved, even, odd
// (R17) Stop bit count affects transmitter only
// (R18) Size codes give five to nine bits
// (R19) Clock polarity picks change and sample edges
// (R20) Twelve-bit divisor split over two registers
// (R21) Receive-done shows unread characters present
// (R22) Data writes ignored while buffer full
// (R23) Low divisor write reloads prescaler at once
// (R24) Bit period from prescaler and oversampling
module usx_regs
    import usx_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire usx_bus_req_t bus, // Register request
    output logic [7:0] rdata, // Read data
    input wire logic global_irq_en, // Global interrupt enable
    input wire logic tx_irq_ack, // Transmit-done serviced
    input wire logic rxd_pin, // Serial receive pin
    output logic txd, // Serial transmit data
    output logic txd_oe_n, // Transmit pin enable
    output logic external_serial_clock, // Synchronous clock out
    output logic xck_oe_n, // Clock pin enable
    output logic rx_irq, // Receive-done request
    output logic tx_irq, // Transmit-done request
    output logic udre_irq // Buffer-empty request
);

    function automatic logic [3:0] char_bits(input logic [2:0] code);
        case (code)
            3'h0: char_bits = 4'h5;
            3'h1: char_bits = 4'h6;
            3'h2: char_bits = 4'h7;
            3'h7: char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction : char_bits

    usx_state_t st;
    usx_state_t nx;
    usx_rx_ent_t ent;
    usx_rx_ent_t head;
    logic sync_mode;
    logic cpol;
    logic par_on;
    logic par_odd;
    logic tick;
    logic chg_edge;
    logic smp_edge;
    logic tx_bit;
    logic rx_bit;
    logic tx_done;
    logic push;
    logic pop;
    logic start_seen;
    logic hv;
    logic [1:0] n;
    logic [3:0] os_max;
    logic [3:0] nbits;

    always_comb begin
        nx = st;
        ent = '0;
        push = 1'b0;
        tx_done = 1'b0;
        start_seen = 1'b0;
        sync_mode = st.fmt[C_MSEL]; // [R15]
        cpol = st.fmt[C_CPOL] & sync_mode;
        par_on = st.fmt[C_PAR_HI]; // [R16]
        par_odd = st.fmt[C_PAR_LO];
        nbits = char_bits({st.ctrl_b[B_CSZ2], st.fmt[C_CSZ_HI:C_CSZ_LO]}); // [R18]
        os_max = (st.u2x && !sync_mode) ? OS_DOUBLE : OS_NORMAL; // [R8]
        head = (st.fifo_n != 2'h0) ? st.fifo[0] : '0;
        pop = bus.re && bus.addr == ADDR_DATA && st.fifo_n != 2'h0;

        // Pin synchroniser
        nx.rx_s1 = rxd_pin;
        nx.rx_s2 = st.rx_s1;
        nx.rx_s3 = st.rx_s2;
        if (st.rx_s2 == st.rx_s3) begin
            nx.rxd = st.rx_s3;
        end

        // Prescaler: one tick every divisor+1 clocks
        tick = st.presc == 12'h000; // [R24]
        if (bus.we && bus.addr == ADDR_BAUD_LO) begin
            nx.presc = {st.baud[11:8], bus.wdata}; // [R23]
            tick = 1'b0;
        end else if (tick) begin
            nx.presc = st.baud;
        end else begin
            nx.presc = st.presc - 12'h001;
        end

        // Synchronous clock and its edges
        chg_edge = sync_mode && tick && (st.external_serial_clock == cpol); // [R19]
        smp_edge = sync_mode && tick && (st.external_serial_clock != cpol); // [R19]
        if (!sync_mode) begin
            nx.external_serial_clock = 1'b0;
        end else if (tick) begin
            nx.external_serial_clock = ~st.external_serial_clock;
        end
        if (tick) begin
            nx.tx_os = (st.tx_os >= os_max) ? 4'h0 : st.tx_os + 4'h1;
            nx.rx_os = (st.rx_os >= os_max) ? 4'h0 : st.rx_os + 4'h1;
        end
        tx_bit = sync_mode ? chg_edge : (tick && st.tx_os == os_max); // [R24]
        rx_bit = sync_mode ? smp_edge : (tick && st.rx_os == {1'b0, os_max[3:1]});

        // Transmitter
        nx.tx_on = st.ctrl_b[B_TXEN] | (st.tx_on & ((st.tx_st != TX_IDLE) | st.tx_full)); // [R12]
        if (bus.we && bus.addr == ADDR_DATA && !st.tx_full) begin // [R22]
            nx.tx_buf = {st.ctrl_b[B_TXB8], bus.wdata};
            nx.tx_full = 1'b1;
        end
        unique case (st.tx_st)
            TX_IDLE: begin
                if (st.tx_on && st.tx_full) begin
                    nx.tx_sh = st.tx_buf;
                    nx.tx_full = 1'b0;
                    nx.tx_st = TX_START;
                    nx.txd = 1'b0;
                    nx.tx_os = 4'h0;
                    nx.tx_par = par_odd;
                end
            end
            TX_START: begin
                if (tx_bit) begin
                    nx.txd = st.tx_sh[0];
                    nx.tx_par = st.tx_par ^ st.tx_sh[0];
                    nx.tx_sh = st.tx_sh >> 1;
                    nx.tx_cnt = 4'h1;
                    nx.tx_st = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_bit) begin
                    if (st.tx_cnt == nbits) begin
                        if (par_on) begin
                            nx.txd = st.tx_par; // [R16]
                            nx.tx_st = TX_PAR;
                        end else begin
                            nx.txd = 1'b1;
                            nx.tx_st = TX_STOP1;
                        end
                    end else begin
                        nx.txd = st.tx_sh[0];
                        nx.tx_par = st.tx_par ^ st.tx_sh[0];
                        nx.tx_sh = st.tx_sh >> 1;
                        nx.tx_cnt = st.tx_cnt + 4'h1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_bit) begin
                    nx.txd = 1'b1;
                    nx.tx_st = TX_STOP1;
                end
            end
            TX_STOP1: begin
                if (tx_bit) begin
                    if (st.fmt[C_STOP]) begin // [R17]
                        nx.tx_st = TX_STOP2;
                    end else begin
                        tx_done = 1'b1;
                    end
                end
            end
            TX_STOP2: begin
                if (tx_bit) begin
                    tx_done = 1'b1;
                end
            end
            default: nx.tx_st = TX_IDLE;
        endcase
        if (tx_done) begin
            nx.tx_st = TX_IDLE;
        end
        if (!nx.tx_on) begin
            nx.txd = 1'b1;
        end
        // Set wins over service and write-one clear
        nx.txc = (tx_done && !st.tx_full) // [R1]
            | (st.txc & ~tx_irq_ack & ~(bus.we && bus.addr == ADDR_STATUS && bus.wdata[A_TXC])); // [R2]

        // Receiver
        unique case (st.rx_st)
            RX_IDLE: begin
                if (st.ctrl_b[B_RXEN] && !st.rxd && (sync_mode ? smp_edge : tick)) begin // [R11]
                    start_seen = 1'b1;
                    nx.rx_st = sync_mode ? RX_DATA : RX_START;
                    nx.rx_os = 4'h1;
                    nx.rx_cnt = 4'h0;
                    nx.rx_sh = 9'h000;
                    nx.rx_par = par_odd;
                    nx.rx_pe = 1'b0;
                end
            end
            RX_START: begin
                if (rx_bit) begin
                    nx.rx_st = st.rxd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_bit) begin
                    nx.rx_sh[st.rx_cnt] = st.rxd;
                    nx.rx_par = st.rx_par ^ st.rxd;
                    nx.rx_cnt = st.rx_cnt + 4'h1;
                    if (st.rx_cnt + 4'h1 == nbits) begin
                        nx.rx_st = par_on ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_bit) begin
                    nx.rx_pe = st.rxd ^ st.rx_par; // [R6]
                    nx.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_bit) begin
                    ent.data = st.rx_sh;
                    ent.fe = ~st.rxd; // [R4]
                    ent.pe = st.rx_pe; // [R6]
                    push = !st.mpcm || st.rx_sh[nbits - 4'h1]; // [R9]
                    nx.rx_st = RX_IDLE;
                end
            end
            default: nx.rx_st = RX_IDLE;
        endcase

        // Two-entry buffer with a holding stage behind it
        n = st.fifo_n;
        hv = st.hold_v;
        if (pop) begin
            nx.fifo[0] = st.fifo[1];
            n = n - 2'h1;
        end
        if (hv && n != FIFO_DEPTH) begin
            nx.fifo[n[0]] = st.hold;
            n = n + 2'h1;
            hv = 1'b0;
        end
        if (push) begin
            if (n != FIFO_DEPTH) begin
                nx.fifo[n[0]] = ent;
                n = n + 2'h1;
            end else if (!hv) begin
                nx.hold = ent;
                hv = 1'b1;
            end
        end
        nx.fifo_n = n;
        nx.hold_v = hv;
        nx.dor = (start_seen && st.fifo_n == FIFO_DEPTH && st.hold_v) | (st.dor & ~pop); // [R5]

        // Register writes
        if (bus.we) begin
            case (bus.addr)
                ADDR_STATUS: begin
                    nx.u2x = bus.wdata[A_U2X];
                    nx.mpcm = bus.wdata[A_MPCM];
                end
                ADDR_CTRL: nx.ctrl_b = bus.wdata;
                ADDR_FORMAT: nx.fmt = bus.wdata & FORMAT_MASK;
                ADDR_BAUD_LO: nx.baud[7:0] = bus.wdata; // [R20]
                ADDR_BAUD_HI: nx.baud[11:8] = bus.wdata[3:0]; // [R20]
                default: nx.u2x = st.u2x;
            endcase
        end

        if (!st.ctrl_b[B_RXEN]) begin // [R11]
            nx.fifo_n = 2'h0;
            nx.hold_v = 1'b0;
            nx.dor = 1'b0;
            nx.rx_st = RX_IDLE;
        end

        // Register reads, answered in the following cycle
        nx.rdata = 8'h00;
        if (bus.re) begin
            case (bus.addr)
                ADDR_STATUS: nx.rdata = {st.fifo_n != 2'h0, st.txc, ~st.tx_full, // [R21] [R3]
                    head.fe, st.dor, head.pe, st.u2x, st.mpcm}; // [R4] [R5] [R6]
                ADDR_CTRL: nx.rdata = {st.ctrl_b[7:2], head.data[8], st.ctrl_b[B_TXB8]};
                ADDR_FORMAT: nx.rdata = st.fmt;
                ADDR_DATA: nx.rdata = head.data[7:0];
                ADDR_BAUD_LO: nx.rdata = st.baud[7:0];
                ADDR_BAUD_HI: nx.rdata = {4'h0, st.baud[11:8]}; // [R20]
                default: nx.rdata = 8'h00;
            endcase
        end

        // Interrupt requests track the registered flags
        nx.irq_rx = global_irq_en & nx.ctrl_b[B_RXCIE] & (nx.fifo_n != 2'h0); // [R10]
        nx.irq_tx = global_irq_en & nx.ctrl_b[B_TXCIE] & nx.txc; // [R10]
        nx.irq_udre = global_irq_en & nx.ctrl_b[B_UDRIE] & ~nx.tx_full; // [R10]
        nx.txd_oe_n = ~nx.tx_on; // [R12]
        nx.xck_oe_n = ~nx.fmt[C_MSEL];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
            st.fmt <= FORMAT_RESET;
            st.baud <= BAUD_RESET;
            st.txd <= 1'b1;
            st.txd_oe_n <= 1'b1;
            st.xck_oe_n <= 1'b1;
            st.rx_s1 <= 1'b1;
            st.rx_s2 <= 1'b1;
            st.rx_s3 <= 1'b1;
            st.rxd <= 1'b1;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign rdata = st.rdata;
    assign txd = st.txd;
    assign txd_oe_n = st.txd_oe_n;
    assign external_serial_clock = st.external_serial_clock;
    assign xck_oe_n = st.xck_oe_n;
    assign rx_irq = st.irq_rx;
    assign tx_irq = st.irq_tx;
    assign udre_irq = st.irq_udre;

endmodule : usx_regs

// File: tb/test_usx_regs.sv
// Testbench for the serial transceiver register block.
// Assumes usx_pkg, the bound checker and the remote node model.
`timescale 1ns/1ps
module test_usx_regs
    import usx_pkg::*;
;
    // Transmit cases: 5E1, 6O1 double speed, 7N2, 9N1
    localparam logic [7:0] FMT [4] = '{8'h20, 8'h32, 8'h0C, 8'h06};
    localparam logic [8:0] DAT [4] = '{9'h013, 9'h02D, 9'h055, 9'h1A5};
    localparam logic [10:0] EXP [4] = '{11'h073, 11'h0ED, 11'h0D5, 11'h3A5};
    localparam int NB [4] = '{6, 7, 7, 9};
    localparam logic [7:0] RXS [3] = '{8'h84, 8'h90, 8'h80};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    usx_bus_req_t bus = '0;
    logic global_irq_en = 1'b1;
    logic tx_irq_ack = 1'b0;
    logic rxd_pin, txd, txd_oe_n, external_serial_clock, xck_oe_n, rx_irq, tx_irq, udre_irq;
    logic [7:0] rdata;
    logic [10:0] f;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2.5 sys_clk = ~sys_clk;

    usx_regs i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
        .global_irq_en(global_irq_en), .tx_irq_ack(tx_irq_ack), .rxd_pin(rxd_pin), .txd(txd),
        .txd_oe_n(txd_oe_n), .external_serial_clock(external_serial_clock), .xck_oe_n(xck_oe_n), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .udre_irq(udre_irq));
    usx_node i_node (.sys_clk(sys_clk), .txd(txd), .rxd(rxd_pin));

    task automatic give_verdict();
        $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("mismatch at %0t: run timed out", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic got, input logic exp);
        chk({10'b0, got}, {10'b0, exp});
    endtask : pin
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        chk({3'b000, rdata & m}, {3'b000, exp});
        @(posedge sys_clk);
    endtask : rdchk

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdchk(ADDR_STATUS, 8'hFF, 8'h20);
        rdchk(ADDR_FORMAT, 8'hFF, 8'h06);
        rdchk(ADDR_BAUD_LO, 8'hFF, 8'h00);
        rdchk(8'hC3, 8'hFF, 8'h00);
        wr(ADDR_BAUD_HI, 8'hFF);
        rdchk(ADDR_BAUD_HI, 8'hFF, 8'h0F);
        wr(ADDR_BAUD_HI, 8'h00);
        ce <= 1'b0;
        wr(ADDR_FORMAT, 8'h7F);
        ce <= 1'b1;
        rdchk(ADDR_FORMAT, 8'hFF, 8'h06);
        wr(ADDR_BAUD_LO, 8'h01);
        $display("test registers done");
        wr(ADDR_CTRL, 8'h20);
        global_irq_en <= 1'b0;
        repeat (2) @(posedge sys_clk);
        pin(udre_irq, 1'b0);
        global_irq_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        pin(udre_irq, 1'b1);
        wr(ADDR_DATA, 8'h5A);
        pin(udre_irq, 1'b0);
        wr(ADDR_DATA, 8'h77);
        pin(txd_oe_n, 1'b1);
        fork
            i_node.take(f, 8, 32);
            begin
                wr(ADDR_CTRL, 8'h28);
                wr(ADDR_CTRL, 8'h20);
            end
        join
        chk(f, 11'h15A);
        repeat (40) @(posedge sys_clk);
        pin(txd_oe_n, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_FORMAT, FMT[i]);
            wr(ADDR_STATUS, (i == 1) ? 8'h42 : 8'h40);
            pin(tx_irq, 1'b0);
            wr(ADDR_CTRL, (i == 3) ? 8'h4D : 8'h48);
            fork
                i_node.take(f, NB[i], (i == 1) ? 16 : 32);
                wr(ADDR_DATA, DAT[i][7:0]);
            join
            chk(f, EXP[i]);
            repeat (56) @(posedge sys_clk);
            pin(tx_irq, 1'b1);
        end
        tx_irq_ack <= 1'b1;
        @(posedge sys_clk);
        tx_irq_ack <= 1'b0;
        @(posedge sys_clk);
        pin(tx_irq, 1'b0);
        wr(ADDR_FORMAT, 8'h46);
        @(posedge sys_clk);
        pin(xck_oe_n, 1'b0);
        $display("test transmit done");
        wr(ADDR_BAUD_LO, 8'h00);
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_FORMAT, 8'h26);
        wr(ADDR_CTRL, 8'h90);
        for (int i = 0; i < 3; i++) begin
            i_node.send({1'b0, i == 0, 8'h3C}, 9, 16, i != 1);
            repeat (20) @(posedge sys_clk);
            rdchk(ADDR_STATUS, 8'h9C, RXS[i]);
            rdchk(ADDR_DATA, 8'hFF, 8'h3C);
        end
        rdchk(ADDR_STATUS, 8'h9C, 8'h00);
        wr(ADDR_FORMAT, 8'h06);
        for (int i = 1; i < 5; i++) begin
            i_node.send(10'(i * 17), 8, 16, 1'b1);
        end
        repeat (20) @(posedge sys_clk);
        rdchk(ADDR_STATUS, 8'h88, 8'h88);
        rdchk(ADDR_DATA, 8'hFF, 8'h11);
        rdchk(ADDR_STATUS, 8'h08, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        rdchk(ADDR_STATUS, 8'h9C, 8'h00);
        wr(ADDR_CTRL, 8'h94);
        wr(ADDR_STATUS, 8'h01);
        i_node.send(10'h03C, 9, 16, 1'b1);
        i_node.send(10'h1BC, 9, 16, 1'b1);
        repeat (20) @(posedge sys_clk);
        rdchk(ADDR_CTRL, 8'h02, 8'h02);
        rdchk(ADDR_DATA, 8'hFF, 8'hBC);
        rdchk(ADDR_STATUS, 8'h80, 8'h00);
        $display("test receive done");
        give_verdict();
    end
endmodule : test_usx_regs

// File: tb/usx_node.sv
// Remote serial node: sends frames to the receive pin, captures the transmit pin.
// Assumes callers start each task just after a rising clock edge.
`timescale 1ns/1ps
module usx_node (
    input wire logic sys_clk, // System clock
    input wire logic txd, // Device transmit line
    output logic rxd // Device receive line
);
    initial rxd = 1'b1;
    task automatic send(input logic [9:0] d, input int nb, input int bc, input logic stop);
        rxd <= 1'b0;
        repeat (bc) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (bc) @(posedge sys_clk);
        end
        rxd <= stop;
        // A broken stop lasts half a bit so no false start follows it
        repeat (stop ? bc : bc / 2) @(posedge sys_clk);
        if (!stop) begin
            rxd <= 1'b1; // Back to idle mark after a broken stop
            repeat (bc) @(posedge sys_clk);
        end
    endtask : send
    task automatic take(output logic [10:0] d, input int nb, input int bc);
        d = '0;
        @(negedge txd);
        repeat (bc / 2) @(posedge sys_clk);
        for (int i = 0; i <= nb; i++) begin
            repeat (bc) @(posedge sys_clk);
            d[i] = txd; // Mid-bit sample, stop bit last
        end
    endtask : take
endmodule : usx_node

// File: tb/usx_regs_assertions.sv
// Port checker for the serial transceiver register block.
// Assumes usx_pkg is compiled first; bound to every usx_regs.
`timescale 1ns/1ps
module usx_regs_assertions
    import usx_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic ce, // Clock enable
    input wire usx_bus_req_t bus, // Request
    input wire logic [7:0] rdata, // Read data
    input wire logic global_irq_en, // Global enable
    input wire logic tx_irq_ack, // Service pulse
    input wire logic rxd_pin, // Receive pin
    input wire logic txd, // Transmit pin
    input wire logic txd_oe_n, // Transmit pin enable
    input wire logic external_serial_clock, // Sync clock
    input wire logic xck_oe_n, // Clock pin enable
    input wire logic rx_irq, // Receive request
    input wire logic tx_irq, // Transmit request
    input wire logic udre_irq // Empty request
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_data_wr;
        ce && bus.we && bus.addr == ADDR_DATA;
    endsequence
    sequence s_hi_rd;
        ce && bus.re && bus.addr == ADDR_BAUD_HI;
    endsequence
    sequence s_rx_off;
        ce && bus.we && bus.addr == ADDR_CTRL && !bus.wdata[B_RXEN];
    endsequence
    sequence s_txc_wr1;
        ce && bus.we && bus.addr == ADDR_STATUS && bus.wdata[A_TXC];
    endsequence

    a_divisor_high_zero: assert property (s_hi_rd |=> rdata[7:4] == 4'h0)
        else $error("divisor high reserved bits not zero");
    a_irq_gated: assert property (ce && !global_irq_en |=> !rx_irq && !tx_irq && !udre_irq)
        else $error("request raised without global enable");
    a_rx_needs_global: assert property (rx_irq && $past(ce) |-> $past(global_irq_en))
        else $error("receive request without global enable");
    a_data_wr_full: assert property (s_data_wr ##0 udre_irq |=> !udre_irq)
        else $error("buffer empty request stayed after data write");
    a_txc_write_clear: assert property (s_txc_wr1 |=> !tx_irq)
        else $error("transmit done not cleared by write of one");
    a_ack_clear: assert property (ce && tx_irq_ack |=> !tx_irq)
        else $error("transmit done not cleared by service");
    a_rx_flush: assert property (s_rx_off |=> ##1 !rx_irq)
        else $error("receive request survived receiver disable");
    a_txd_released: assert property (txd_oe_n |-> txd)
        else $error("transmit line not idle while released");
    a_xck_async: assert property (xck_oe_n && $past(xck_oe_n) |-> !external_serial_clock)
        else $error("sync clock moving in asynchronous mode");
endmodule : usx_regs_assertions

bind usx_regs usx_regs_assertions i_chk (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .global_irq_en(global_irq_en),
    .tx_irq_ack(tx_irq_ack), .rxd_pin(rxd_pin), .txd(txd), .txd_oe_n(txd_oe_n), .external_serial_clock(external_serial_clock),
    .xck_oe_n(xck_oe_n), .rx_irq(rx_irq), .tx_irq(tx_irq), .udre_irq(udre_irq)
);
